// *** rtl/reset_control_sequencer.sv ***
// reset control sequencer: forced halt, control clear and core init
// assumes wake pin, supply-low flag and carry pulse are synchronous to CLK_I
//
// Behaviour
// (R1) wake pin rising edge starts chip-enable reset
// (R2) after rise, init applied on next carry pulse; code asserts init at the rise and releases it on the carry
// (R3) power-on clears all registers, restart at zero
// (R4) chip-enable clears core and some registers
// (R5) forced halt on power-on and stop only
// (R6) control clear on power-on and stop only
// (R7) core init asserted for every reset kind
// (R8) stop instruction also activates reset logic
// (R9) supply-low release performs power-on reset
// (R10) stop disables display, colour outputs low
// (R11) stop drives all pulse-width outputs low
// (R12) stop: oscillator out high, input pulled low
// (R13) halt keeps display pins at held values
// (R14) stop clears timer mode to slow period
// (R15) plain chip-enable keeps timer mode unchanged
// (R16) forced halt held while wake pin low
// (R17) supply-low asserts all resets, stops oscillator
// (R18) supply-low and carry pulse sampled synchronously
`timescale 1ns/1ps
module reset_control_sequencer (
  // clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RST_B_I,
  // reset sources
  input  wire logic                        WAKE_I,
  input  wire logic                        SUPPLY_LOW_FLAG_I,
  input  wire logic                        STOP_EXEC_I,
  input  wire logic                        CARRY_PULSE_I,
  // timer mode written by the core
  input  wire logic                        TMODE_WE_I,
  input  wire logic [3:0]                  TMODE_WD_I,
  // core halt instruction state and live pin values
  input  wire logic                        HALT_I,
  input  wire rst_seq_pkg::display_pins_t  DISP_I,
  input  wire logic [3:0]                  PWM_I,
  // internal resets
  output logic                             FORCED_HALT_SIGNAL_O,
  output logic                             CONTROL_REG_CLEAR_O,
  output logic                             CORE_INIT_O,
  output logic                             FULL_CLEAR_O,
  output logic [15:0]                      START_ADDR_O,
  // oscillator and timer mode
  output logic                             OSC_RUN_O,
  output logic [3:0]                       TMODE_O,
  output logic                             STOPPED_O,
  // pins
  output logic                             DISPLAY_ENABLE_FLAG_O,
  output rst_seq_pkg::display_pins_t       DISP_O,
  output logic [3:0]                       PWM_O,
  output logic                             XOUT_O,
  output logic                             XIN_PULLDOWN_O
);

  ////////////////////////////////////////////////////////////////////////
  // state

  rst_seq_pkg::seq_state_t state_r, state_nxt;
  rst_seq_pkg::reset_bus_t rst_r, rst_nxt;
  logic                    wake_r, wake_nxt;
  logic                    carry_r, carry_nxt;
  logic                    full_r, full_nxt;
  logic                    osc_r, osc_nxt;
  logic [3:0]              tmode_r, tmode_nxt;
  logic                    wake_rise;
  logic                    carry_rise;

  // edge detect on plain synchronous inputs
  assign wake_rise  = WAKE_I && !wake_r;                   // R1
  assign carry_rise = CARRY_PULSE_I && !carry_r;           // R18

  ////////////////////////////////////////////////////////////////////////
  // sequencer next state
  // supply-low outranks stop, stop outranks a wake edge
  always_comb begin
    state_nxt = state_r;
    rst_nxt   = rst_r;
    full_nxt  = full_r;
    osc_nxt   = 1'b1;
    tmode_nxt = tmode_r;
    wake_nxt  = WAKE_I;
    carry_nxt = CARRY_PULSE_I;
    if (TMODE_WE_I && state_r == rst_seq_pkg::ST_RUN) begin
      tmode_nxt = TMODE_WD_I;                              // R15
    end
    case (state_r)
      rst_seq_pkg::ST_RUN: begin
        rst_nxt = '0;
        if (STOP_EXEC_I) begin
          state_nxt = rst_seq_pkg::ST_STOP;                // R8
          rst_nxt   = '{forced_halt: 1'b1, ctrl_clear: 1'b1, core_init: 1'b1}; // R5
          full_nxt  = 1'b0;
          tmode_nxt = rst_seq_pkg::TMODE_CLR;              // R14
        end else if (wake_rise) begin
          state_nxt = rst_seq_pkg::ST_WAIT;                // R2
          rst_nxt   = '{forced_halt: 1'b0, ctrl_clear: 1'b0, core_init: 1'b1}; // R7
          full_nxt  = 1'b0;                                // R4
        end
      end
      rst_seq_pkg::ST_STOP: begin
        osc_nxt = WAKE_I;                                  // R16
        if (wake_rise) begin
          state_nxt = rst_seq_pkg::ST_WAIT;
          rst_nxt.ctrl_clear = 1'b0;                       // R6
        end
      end
      rst_seq_pkg::ST_WAIT: begin
        if (!WAKE_I && rst_r.forced_halt) begin
          state_nxt = rst_seq_pkg::ST_STOP;                // R16
        end else if (carry_rise) begin
          state_nxt = rst_seq_pkg::ST_RUN;                 // R2
          rst_nxt   = '0;
        end
      end
      rst_seq_pkg::ST_LOW: begin
        // clock restarts the cycle after the flag drops; the override below
        // keeps it off for as long as the supply stays low
        osc_nxt = 1'b1;                                    // R9
        if (!SUPPLY_LOW_FLAG_I) begin
          state_nxt = rst_seq_pkg::ST_WAIT;                // R9
          rst_nxt   = '{forced_halt: 1'b1, ctrl_clear: 1'b0, core_init: 1'b0};
        end
      end
      default: begin
        state_nxt = rst_seq_pkg::ST_RUN;
        rst_nxt   = '0;
      end
    endcase
    if (SUPPLY_LOW_FLAG_I) begin
      state_nxt = rst_seq_pkg::ST_LOW;                     // R17
      rst_nxt   = '{forced_halt: 1'b1, ctrl_clear: 1'b1, core_init: 1'b1}; // R6
      full_nxt  = 1'b1;                                    // R3
      osc_nxt   = 1'b0;
      tmode_nxt = rst_seq_pkg::TMODE_CLR;
    end
  end

  // sequencer registers; hardware reset behaves as a power-on clear
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_r <= rst_seq_pkg::ST_LOW;
      rst_r   <= '{forced_halt: 1'b1, ctrl_clear: 1'b1, core_init: 1'b1};
      full_r  <= 1'b1;
      osc_r   <= 1'b0;
      tmode_r <= rst_seq_pkg::TMODE_CLR;
      wake_r  <= 1'b0;
      carry_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rst_r   <= rst_nxt;
      full_r  <= full_nxt;
      osc_r   <= osc_nxt;
      tmode_r <= tmode_nxt;
      wake_r  <= wake_nxt;
      carry_r <= carry_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  logic stop_r;
  assign stop_r = (state_r == rst_seq_pkg::ST_STOP);

  assign FORCED_HALT_SIGNAL_O  = rst_r.forced_halt;
  assign CONTROL_REG_CLEAR_O   = rst_r.ctrl_clear;
  assign CORE_INIT_O           = rst_r.core_init;
  assign FULL_CLEAR_O          = full_r;
  assign START_ADDR_O          = rst_seq_pkg::START_ADDR;  // R3
  assign OSC_RUN_O             = osc_r;
  assign TMODE_O               = tmode_r;
  assign STOPPED_O             = stop_r;

  logic den_r;
  // display enable drops in stop; no display in stop
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      den_r <= 1'b0;
    end else begin
      den_r <= (state_nxt != rst_seq_pkg::ST_STOP);      // R10
    end
  end
  assign DISPLAY_ENABLE_FLAG_O = den_r;

  // pin holder keyed from registered state
  pin_hold u_pins (
    .CLK_I    (CLK_I),
    .RST_B_I  (RST_B_I),
    .halt_i   (HALT_I),
    .stop_i   (stop_r),
    .disp_i   (DISP_I),
    .pwm_i    (PWM_I),
    .disp_o   (DISP_O),
    .pwm_o    (PWM_O),
    .xout_o   (XOUT_O),
    .xin_pd_o (XIN_PULLDOWN_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks

  wake_init_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && wake_rise && !STOP_EXEC_I && !SUPPLY_LOW_FLAG_I)
      |=> (CORE_INIT_O && !FORCED_HALT_SIGNAL_O && !CONTROL_REG_CLEAR_O)) // R1
    else $error("wake edge did not start chip-enable reset");

  carry_release_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_WAIT && carry_rise && WAKE_I && !SUPPLY_LOW_FLAG_I)
      |=> !CORE_INIT_O) // R2
    else $error("carry pulse did not release reset");

  stop_all_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && STOP_EXEC_I && !SUPPLY_LOW_FLAG_I)
      |=> (FORCED_HALT_SIGNAL_O && CONTROL_REG_CLEAR_O && CORE_INIT_O && TMODE_O == 4'h0)) // R8
    else $error("stop did not raise all resets");

  ce_keep_mode_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_WAIT && !rst_r.forced_halt && !SUPPLY_LOW_FLAG_I)
      |=> $stable(TMODE_O)) // R15
    else $error("chip-enable reset altered timer mode");

  halt_low_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_STOP && !WAKE_I && !SUPPLY_LOW_FLAG_I)
      |=> FORCED_HALT_SIGNAL_O [*2]) // R16
    else $error("forced halt dropped while wake low");

  supply_low_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    SUPPLY_LOW_FLAG_I |=> (FULL_CLEAR_O && CONTROL_REG_CLEAR_O && !OSC_RUN_O)) // R17
    else $error("supply low did not clear all");

  por_release_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_LOW && !SUPPLY_LOW_FLAG_I)
      |=> (FORCED_HALT_SIGNAL_O && !CONTROL_REG_CLEAR_O && OSC_RUN_O)) // R9
    else $error("supply release did not enter wait");

  stop_pins_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    stop_r |=> (stop_r || $past(stop_r)) && (!stop_r || (PWM_O == 4'h0 && XOUT_O))) // R11
    else $error("stop pins not forced");

  ////////////////////////////////////////////////////////////////////////
  // sequencing checks on the run, wait and stop states

  // mode write lands only while running
  tmode_write_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && TMODE_WE_I && !STOP_EXEC_I && !SUPPLY_LOW_FLAG_I)
      |=> (TMODE_O == $past(TMODE_WD_I))) // R15
    else $error("timer mode write lost");

  // no release without a carry edge
  wait_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_WAIT && !carry_rise && WAKE_I && !SUPPLY_LOW_FLAG_I)
      |=> ($stable(CORE_INIT_O) && $stable(FORCED_HALT_SIGNAL_O) && !STOPPED_O)) // R2
    else $error("reset released without carry edge");

  // quiet running keeps all resets low
  run_quiet_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && !STOP_EXEC_I && !wake_rise && !SUPPLY_LOW_FLAG_I)
      |=> !(FORCED_HALT_SIGNAL_O || CONTROL_REG_CLEAR_O || CORE_INIT_O)) // R7
    else $error("reset raised with no cause");

  // display off in every stop cycle
  stop_display_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_STOP) |-> !DISPLAY_ENABLE_FLAG_O) // R10
    else $error("display enabled during stop");

  // stop always leaves the slow carry period selected
  stop_mode_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_STOP) |-> (TMODE_O == rst_seq_pkg::TMODE_CLR)) // R14
    else $error("timer mode not cleared in stop");

  // oscillator stays off in stop while the wake pin is low
  stop_osc_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_STOP && !WAKE_I && !SUPPLY_LOW_FLAG_I)
      |=> !OSC_RUN_O) // R16
    else $error("oscillator ran with wake pin low");

  // wake edge in stop drops only the control clear
  stop_wake_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_STOP && wake_rise && !SUPPLY_LOW_FLAG_I)
      |=> (!CONTROL_REG_CLEAR_O && FORCED_HALT_SIGNAL_O && CORE_INIT_O)) // R6
    else $error("wake in stop left clear raised");

  // chip-enable reset is a partial clear from address zero
  ce_partial_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && wake_rise && !STOP_EXEC_I && !SUPPLY_LOW_FLAG_I)
      |=> (!FULL_CLEAR_O && START_ADDR_O == rst_seq_pkg::START_ADDR)) // R4
    else $error("chip-enable reset cleared everything");

  // stop instruction enters the stop state at once
  stop_enter_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (state_r == rst_seq_pkg::ST_RUN && STOP_EXEC_I && !SUPPLY_LOW_FLAG_I)
      |=> (STOPPED_O && !DISPLAY_ENABLE_FLAG_O)) // R8
    else $error("stop instruction not taken");

endmodule

// *** rtl/rst_seq_pkg.sv ***
// package for the reset control sequencer: constants and carrier types
// assumes a single 200 MHz system clock domain
package rst_seq_pkg;

  // clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // timer mode selection field: width and value after a clear
  localparam int unsigned TMODE_W       = 4;
  localparam logic [3:0]  TMODE_CLR     = 4'h0;
  // mode code that selects the 5 ms carry period
  localparam logic [3:0]  TMODE_FAST    = 4'h1;

  // carry pulse periods in milliseconds
  localparam int unsigned CARRY_SLOW_MS = 100;
  localparam int unsigned CARRY_FAST_MS = 5;

  // restart address after any reset
  localparam logic [15:0] START_ADDR    = 16'h0000;

  // number of pulse-width outputs
  localparam int unsigned PWM_N         = 4;

  // sequencer states
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_WAIT  = 2'b01,
    ST_STOP  = 2'b10,
    ST_LOW   = 2'b11
  } seq_state_t;

  // internal reset signals, all active high inside the block
  typedef struct packed {
    logic forced_halt;
    logic ctrl_clear;
    logic core_init;
  } reset_bus_t;

  // display pin group
  typedef struct packed {
    logic red;
    logic green;
    logic blue;
    logic blank;
    logic hsync;
    logic vsync;
  } display_pins_t;

endpackage

// *** rtl/pin_hold.sv ***
// pin state holder for halt and clock-stop
// assumes the core presents live pin values every cycle
`timescale 1ns/1ps
module pin_hold (
  // clock and reset
  input  wire logic                       CLK_I,
  input  wire logic                       RST_B_I,
  // state
  input  wire logic                       halt_i,
  input  wire logic                       stop_i,
  // live values from the core
  input  wire rst_seq_pkg::display_pins_t disp_i,
  input  wire logic [3:0]                 pwm_i,
  // held pin values
  output rst_seq_pkg::display_pins_t      disp_o,
  output logic [3:0]                      pwm_o,
  output logic                            xout_o,
  output logic                            xin_pd_o
);

  rst_seq_pkg::display_pins_t disp_r, disp_nxt;
  logic [3:0]                 pwm_r, pwm_nxt;
  logic                       xout_r, xout_nxt;
  logic                       xpd_r, xpd_nxt;

  // next pin values; halt freezes, stop forces levels
  always_comb begin
    disp_nxt = disp_i;
    pwm_nxt  = pwm_i;
    xout_nxt = 1'b0;
    xpd_nxt  = 1'b0;
    if (stop_i) begin
      disp_nxt = '0;                                       // R10
      pwm_nxt  = '0;                                       // R11
      xout_nxt = 1'b1;                                     // R12
      xpd_nxt  = 1'b1;                                     // R12
    end else if (halt_i) begin
      disp_nxt = disp_r;                                   // R13
      pwm_nxt  = pwm_r;
    end
  end

  // registered outputs
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      disp_r <= '0;
      pwm_r  <= 4'h0;
      xout_r <= 1'b0;
      xpd_r  <= 1'b0;
    end else begin
      disp_r <= disp_nxt;
      pwm_r  <= pwm_nxt;
      xout_r <= xout_nxt;
      xpd_r  <= xpd_nxt;
    end
  end

  assign disp_o   = disp_r;
  assign pwm_o    = pwm_r;
  assign xout_o   = xout_r;
  assign xin_pd_o = xpd_r;

  // frozen display during halt
  hold_freeze_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (halt_i && !stop_i && $past(halt_i)) |=> (disp_r == $past(disp_r))) // R13
    else $error("display pins moved during halt");

endmodule

// *** tb/host_model.sv ***
// host side model: drives wake pin, supply-low flag and timer carry pulse
// assumes requests from the bench; everything launched on CLK_I rising edge
`timescale 1ns/1ps
module host_model #(
  parameter int CARRY_PER = 40
) (
  // clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_B_I,
  // requests from the bench
  input  wire logic wake_req_i,
  input  wire logic low_req_i,
  // pins toward the sequencer
  output logic      wake_o,
  output logic      low_o,
  output logic      carry_o
);
  int cnt_r;

  ////////////////////////////////////////////////////////////////
  // levels and carry launched on the clock edge, never between edges
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wake_o  <= 1'b0;
      low_o   <= 1'b0;
      carry_o <= 1'b0;
      cnt_r   <= 0;
    end else begin
      wake_o  <= wake_req_i;
      low_o   <= low_req_i;
      // free-running carry, short high phase like a set pulse
      cnt_r   <= (cnt_r == CARRY_PER - 1) ? 0 : cnt_r + 1;
      // pulse sits at the end of the period so none lands right after reset
      carry_o <= (cnt_r >= CARRY_PER - 4);
    end
  end
endmodule

// *** tb/reset_control_sequencer_tb.sv ***
// bench for the reset control sequencer
// assumes host_model drives wake, supply-low and carry
`timescale 1ns/1ps
module reset_control_sequencer_tb;
  logic clk = 1'b0, rst_b = 1'b0, wake_req = 1'b1, low_req = 1'b0;
  logic stop = 1'b0, we = 1'b0, halt = 1'b0;
  logic [3:0] wd = 4'h0, pwm_in = 4'h0;
  rst_seq_pkg::display_pins_t disp_in = 6'h00;
  logic wake, low, carry, fh, clr, init, full, osc, stopped, den, xout, xpd;
  logic [15:0] sa;
  logic [3:0]  tm, pwm_out;
  rst_seq_pkg::display_pins_t disp_out;
  int errors = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  host_model #(.CARRY_PER(40)) u_host (.CLK_I(clk), .RST_B_I(rst_b), .wake_req_i(wake_req),
    .low_req_i(low_req), .wake_o(wake), .low_o(low), .carry_o(carry));

  reset_control_sequencer u_dut (.CLK_I(clk), .RST_B_I(rst_b), .WAKE_I(wake),
    .SUPPLY_LOW_FLAG_I(low), .STOP_EXEC_I(stop), .CARRY_PULSE_I(carry), .TMODE_WE_I(we),
    .TMODE_WD_I(wd), .HALT_I(halt), .DISP_I(disp_in), .PWM_I(pwm_in),
    .FORCED_HALT_SIGNAL_O(fh), .CONTROL_REG_CLEAR_O(clr), .CORE_INIT_O(init),
    .FULL_CLEAR_O(full), .START_ADDR_O(sa), .OSC_RUN_O(osc), .TMODE_O(tm), .STOPPED_O(stopped),
    .DISPLAY_ENABLE_FLAG_O(den), .DISP_O(disp_out), .PWM_O(pwm_out), .XOUT_O(xout),
    .XIN_PULLDOWN_O(xpd));

  ////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // all three resets as one value: halt, clear, init
  task automatic chk_rst(input logic [2:0] exp);
    chk("resets", {13'h0, exp}, {13'h0, fh, clr, init});
  endtask

  // bounded wait for the carry edge to release every reset
  task automatic wait_release;
    int n;
    n = 0;
    while ((fh | clr | init) !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    chk_rst(3'h0);
  endtask

  task automatic write_tmode(input logic [3:0] v);
    @(posedge clk);
    we <= 1'b1;
    wd <= v;
    @(posedge clk);
    we <= 1'b0;
    cyc(2);
  endtask

  ////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_power;
    chk_rst(3'h4);
    chk("start addr", 16'h0000, sa);
    wait_release();
    chk("osc run", 16'h1, {15'h0, osc});
    @(posedge clk) low_req <= 1'b1;
    cyc(4);
    chk_rst(3'h7);
    chk("osc stopped", 16'h0, {15'h0, osc});
    chk("tmode cleared", {12'h0, rst_seq_pkg::TMODE_CLR}, {12'h0, tm});
    @(posedge clk) low_req <= 1'b0;
    cyc(4);
    chk_rst(3'h4);
    wait_release();
    $display("test power done");
  endtask

  task automatic test_ce;
    write_tmode(rst_seq_pkg::TMODE_FAST);
    @(posedge clk) wake_req <= 1'b0;
    cyc(3);
    @(posedge clk) wake_req <= 1'b1;
    cyc(4);
    chk_rst(3'h1);
    chk("full clear", 16'h0, {15'h0, full});
    chk("start addr", 16'h0000, sa);
    chk("tmode kept", {12'h0, rst_seq_pkg::TMODE_FAST}, {12'h0, tm});
    // init must hold until the carry pulse rises
    @(posedge carry);
    cyc(1);
    chk_rst(3'h1);
    wait_release();
    $display("test ce done");
  endtask

  task automatic test_stop;
    @(posedge clk);
    pwm_in  <= 4'hF;
    disp_in <= 6'h3F;
    write_tmode(rst_seq_pkg::TMODE_FAST);
    @(posedge clk) wake_req <= 1'b0;
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    cyc(4);
    chk_rst(3'h7);
    chk("stopped", 16'h1, {15'h0, stopped});
    chk("tmode", {12'h0, rst_seq_pkg::TMODE_CLR}, {12'h0, tm});
    chk("display enable", 16'h0, {15'h0, den});
    chk("colours", 16'h0, {13'h0, disp_out.red, disp_out.green, disp_out.blue});
    chk("pwm", 16'h0, {12'h0, pwm_out});
    chk("xout xin", 16'h3, {14'h0, xout, xpd});
    // carry edges while the pin is low must not release the halt
    cyc(90);
    chk_rst(3'h7);
    @(posedge clk) wake_req <= 1'b1;
    cyc(4);
    chk_rst(3'h5);
    wait_release();
    $display("test stop done");
  endtask

  task automatic test_halt;
    @(posedge clk);
    disp_in <= 6'h2A;
    pwm_in  <= 4'h5;
    cyc(3);
    @(posedge clk) halt <= 1'b1;
    cyc(2);
    @(posedge clk) disp_in <= 6'h15;
    cyc(3);
    chk("held display", 16'h002A, {10'h0, disp_out});
    @(posedge clk) halt <= 1'b0;
    cyc(3);
    chk("live display", 16'h0015, {10'h0, disp_out});
    $display("test halt done");
  endtask

  ////////////////////////////////////////////////////////////////
  // verdict, reached by the main sequence or the watchdog
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // whole run is about 260 cycles; allow 10000 cycles, nearly forty times that
  initial begin
    #(10000 * 5);
    errors++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    test_power();
    test_ce();
    test_stop();
    test_halt();
    summarize();
  end
endmodule
